// >>> rtl/hlt_defines.svh
// Purpose: Constants for the hardware limit period timer
// Assumes: 8-bit register port, one clock domain
// Notes: Offsets are word indices on the plain register port
`ifndef HLT_DEFINES_SVH
`define HLT_DEFINES_SVH

`define HLT_ADDR_CTRL 3'h0
`define HLT_ADDR_MODE 3'h1
`define HLT_ADDR_PERIOD 3'h2
`define HLT_ADDR_COUNT 3'h3
`define HLT_ADDR_STATUS 3'h4

`define HLT_CTRL_RUN 0
`define HLT_CTRL_FAST 1

`define HLT_PERIOD_RST 8'hFF
`define HLT_HOLD_CYCLES 2'h2

`define HLT_GRP_FREE 2'h0
`define HLT_GRP_ONE 2'h1
`define HLT_GRP_MONO 2'h2

`endif

// >>> rtl/hlt_pkg.sv
// Purpose: Types for the hardware limit period timer
// Assumes: Used with hlt_defines.svh
// Notes: Whole timer state lives in one packed struct
package hlt_pkg;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hlt_bus_req_t;

    typedef struct packed {
        logic [7:0] count;
        logic match;
        logic counting;
    } hlt_time_base_t;

    typedef struct packed {
        logic run;
        logic fast;
        logic [4:0] mode;
        logic [7:0] period;
        logic [7:0] count;
        logic [1:0] ers_sy;
        logic ers_prev;
        logic [1:0] dbg_sy;
        logic [1:0] run_sy;
        logic started;
        logic [1:0] holdoff;
        logic match;
        logic counting;
        logic [7:0] rdata;
    } hlt_state_t;

endpackage : hlt_pkg

// >>> rtl/hlt_timer.sv
// Purpose: 8-bit period timer with hardware limit, gate and one-shot modes
// Assumes: clock is the timer clock; ers and debug pins are asynchronous
// Notes: fast bit selects instruction-clock style run handling
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "hlt_defines.svh"

module hlt_timer (
    input wire logic clock,
    input wire logic rst,
    input wire hlt_pkg::hlt_bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic external_reset_signal,
    input wire logic debug_mode,
    output hlt_pkg::hlt_time_base_t time_base
);
    import hlt_pkg::*;

    hlt_state_t s_ff;
    hlt_state_t nxt_s;

    logic [1:0] grp;
    logic [2:0] sub;
    logic dbg;
    logic ers_lvl;
    logic rise;
    logic fall;
    logic run_eff;
    logic free_m;
    logic one_m;
    logic mono_m;
    logic lvl_os;
    logic reserved;
    logic start_q;
    logic gate;
    logic edge_rst;
    logic lvl_rst;
    logic wr_run_set;
    logic clr_run;
    logic at_match;

    // Qualifying edge for a 3-bit sub-mode code
    function automatic logic edge_hit(
        input logic [2:0] code,
        input logic r,
        input logic f
    );
        logic hit;
        hit = 1'b0;
        case (code)
            3'h1, 3'h4: hit = r;
            3'h2, 3'h5: hit = f;
            3'h3: hit = r | f;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    always_comb begin
        nxt_s = s_ff;
        grp = s_ff.mode[4:3];
        sub = s_ff.mode[2:0];
        dbg = s_ff.dbg_sy[1];
        // In debug the signal is frozen, so no edge or new level is seen
        ers_lvl = dbg ? s_ff.ers_prev : s_ff.ers_sy[1];
        rise = ers_lvl & ~s_ff.ers_prev;
        fall = ~ers_lvl & s_ff.ers_prev;
        // Slow path costs two clocks but avoids metastable run edges
        run_eff = s_ff.fast ? s_ff.run : s_ff.run_sy[1];
        free_m = (grp == `HLT_GRP_FREE);
        one_m = (grp == `HLT_GRP_ONE) && (sub[2:1] != 2'h3);
        mono_m = (grp == `HLT_GRP_MONO) && (sub != 3'h0) && (sub < 3'h4);
        lvl_os = ((grp == `HLT_GRP_ONE) || (grp == `HLT_GRP_MONO))
            && (sub[2:1] == 2'h3);
        // Reserved codes simply freeze the counter
        reserved = !(free_m || one_m || mono_m || lvl_os);

        start_q = 1'b0;
        if (one_m && (sub == 3'h0)) begin
            start_q = 1'b1;
        end else if (one_m || mono_m) begin
            start_q = edge_hit(sub, rise, fall);
        end else if (lvl_os) begin
            start_q = (ers_lvl == ~sub[0]);
        end

        gate = 1'b1;
        if (free_m && (sub == 3'h1)) begin
            gate = ers_lvl;
        end else if (free_m && (sub == 3'h2)) begin
            gate = ~ers_lvl;
        end

        edge_rst = (free_m && (sub >= 3'h3) && (sub <= 3'h5)
            && edge_hit(sub, rise, fall))
            || (one_m && (sub >= 3'h4) && s_ff.started
            && edge_hit(sub, rise, fall));
        lvl_rst = (free_m && (sub == 3'h6) && !ers_lvl)
            || (free_m && (sub == 3'h7) && ers_lvl)
            || (lvl_os && s_ff.started && (ers_lvl == sub[0]));

        nxt_s.ers_sy = {s_ff.ers_sy[0], external_reset_signal};
        nxt_s.dbg_sy = {s_ff.dbg_sy[0], debug_mode};
        nxt_s.run_sy = {s_ff.run_sy[0], s_ff.run};
        nxt_s.ers_prev = ers_lvl;
        nxt_s.match = 1'b0;
        nxt_s.counting = 1'b0;
        nxt_s.rdata = 8'h00;
        clr_run = 1'b0;
        at_match = (s_ff.count == s_ff.period);

        if (!run_eff) begin
            nxt_s.started = free_m;
        end else if (free_m) begin
            nxt_s.started = 1'b1;
        end else if (!s_ff.started && start_q) begin
            nxt_s.started = 1'b1;
        end

        if (!run_eff || reserved) begin
            nxt_s.count = s_ff.count;
        end else if (edge_rst || lvl_rst) begin
            nxt_s.count = 8'h00;
            nxt_s.holdoff = `HLT_HOLD_CYCLES;
        end else if (s_ff.holdoff != 2'h0) begin
            nxt_s.holdoff = s_ff.holdoff - 2'h1;
        end else if (s_ff.started && gate) begin
            nxt_s.counting = 1'b1;
            if (at_match) begin
                nxt_s.count = 8'h00;
                nxt_s.match = 1'b1;
                if (one_m || lvl_os) begin
                    nxt_s.started = 1'b0;
                    clr_run = 1'b1;
                end else if (mono_m) begin
                    nxt_s.started = 1'b0;
                end
            end else begin
                nxt_s.count = s_ff.count + 8'h01;
            end
        end

        // A software write of run in the match cycle wins over the clear
        wr_run_set = bus.wr && (bus.addr == `HLT_ADDR_CTRL);
        if (wr_run_set) begin
            nxt_s.run = bus.wdata[`HLT_CTRL_RUN];
            nxt_s.fast = bus.wdata[`HLT_CTRL_FAST];
        end else if (clr_run) begin
            nxt_s.run = 1'b0;
        end
        if (bus.wr && (bus.addr == `HLT_ADDR_MODE)) begin
            nxt_s.mode = bus.wdata[4:0];
        end
        if (bus.wr && (bus.addr == `HLT_ADDR_PERIOD)) begin
            nxt_s.period = bus.wdata;
        end
        if (bus.rd) begin
            case (bus.addr)
                `HLT_ADDR_CTRL: nxt_s.rdata = {6'h00, s_ff.fast, s_ff.run};
                `HLT_ADDR_MODE: nxt_s.rdata = {3'h0, s_ff.mode};
                `HLT_ADDR_PERIOD: nxt_s.rdata = s_ff.period;
                `HLT_ADDR_COUNT: nxt_s.rdata = s_ff.count;
                `HLT_ADDR_STATUS: nxt_s.rdata = {4'h0, ers_lvl,
                    (s_ff.holdoff != 2'h0), s_ff.started, run_eff};
                default: nxt_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.period <= `HLT_PERIOD_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rdata = s_ff.rdata;
    assign time_base.count = s_ff.count;
    assign time_base.match = s_ff.match;
    assign time_base.counting = s_ff.counting;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sw_gate_count_a: assert property (
        (s_ff.mode == 5'h00 && run_eff && !at_match)
        |=> s_ff.count == $past(s_ff.count) + 8'h01)
        else $error("software gate count did not advance");

    sw_gate_hold_a: assert property (
        (s_ff.mode == 5'h00 && !run_eff) |=> $stable(s_ff.count))
        else $error("count moved while run is clear");

    period_wrap_a: assert property (
        (run_eff && !reserved && s_ff.started && gate && at_match
        && s_ff.holdoff == 2'h0 && !edge_rst && !lvl_rst)
        |=> (s_ff.count == 8'h00) && s_ff.match)
        else $error("period match did not wrap to zero");

    hw_gate_a: assert property (
        (s_ff.mode == 5'h01 && !ers_lvl) |=> $stable(s_ff.count))
        else $error("active-high gate did not stall");

    edge_holdoff_a: assert property (
        (edge_rst && run_eff && !reserved) |=> (s_ff.count == 8'h00)[*3])
        else $error("count restarted before two clock delay");

    edge_rearm_a: assert property (
        (!run_eff && !free_m) |=> !s_ff.started)
        else $error("edge start kept armed after run cleared");

    one_shot_stop_a: assert property (
        (s_ff.counting && s_ff.started && one_m && at_match
        && run_eff && !edge_rst && gate && s_ff.holdoff == 2'h0)
        ##0 !wr_run_set |=> !s_ff.run && s_ff.count == 8'h00)
        else $error("one-shot did not clear run at match");

    mono_keep_run_a: assert property (
        (mono_m && run_eff && s_ff.started && at_match
        && s_ff.holdoff == 2'h0 && !wr_run_set)
        |=> $stable(s_ff.run) && !s_ff.started && s_ff.count == 8'h00)
        else $error("monostable match mishandled run");

    run_sync_a: assert property (
        ($rose(s_ff.run) && !s_ff.fast && $stable(s_ff.fast))
        |=> (!run_eff || s_ff.fast) ##1 (run_eff || s_ff.fast))
        else $error("run change took effect too early");

    hw_gate_low_a: assert property (
        (s_ff.mode == 5'h02 && ers_lvl) |=> $stable(s_ff.count))
        else $error("active-low gate did not stall");

    gate_open_a: assert property (
        (s_ff.mode == 5'h01 && ers_lvl && run_eff && s_ff.started
        && s_ff.holdoff == 2'h0 && !at_match)
        |=> s_ff.count == $past(s_ff.count) + 8'h01)
        else $error("open gate did not count");

    gate_stretch_a: assert property (
        (s_ff.mode == 5'h01 && !ers_lvl) |=> !s_ff.counting)
        else $error("time base stepped while gated");

    rise_only_a: assert property (
        (s_ff.mode == 5'h04 && fall) |-> !edge_rst)
        else $error("falling edge reset a rising-edge mode");

    edge_reset_a: assert property (
        (s_ff.mode == 5'h04 && rise && run_eff)
        |=> s_ff.count == 8'h00)
        else $error("rising edge did not reset count");

    holdoff_load_a: assert property (
        (edge_rst && run_eff && !reserved)
        |=> s_ff.holdoff == `HLT_HOLD_CYCLES)
        else $error("edge reset did not load holdoff");

    holdoff_end_a: assert property (
        (s_ff.holdoff == 2'h1 && run_eff && !reserved
        && !edge_rst && !lvl_rst)
        |=> s_ff.holdoff == 2'h0 && $stable(s_ff.count))
        else $error("count moved inside holdoff");

    edge_wait_a: assert property (
        (run_eff && (one_m || mono_m) && sub != 3'h0
        && !s_ff.started && !start_q)
        |=> !s_ff.started && $stable(s_ff.count))
        else $error("edge mode started without an edge");

    match_zero_a: assert property (
        s_ff.match |-> s_ff.count == 8'h00)
        else $error("match pulse without zero count");

    one_shot_run_a: assert property (
        ($past(one_m || lvl_os) && s_ff.match && !$past(wr_run_set))
        |-> !s_ff.run)
        else $error("one-shot left run set after match");

    mono_run_kept_a: assert property (
        (mono_m && !wr_run_set) |=> $stable(s_ff.run))
        else $error("monostable changed run by itself");

    run_fast_a: assert property (
        ($rose(s_ff.run) && s_ff.fast) |-> run_eff)
        else $error("fast run not applied next clock");

    ers_sync_a: assert property (
        (!dbg && !$past(rst) && !$past(rst, 2))
        |-> ers_lvl == $past(external_reset_signal, 2))
        else $error("external level not two flops late");

    dbg_sync_a: assert property (
        (!$past(rst) && !$past(rst, 2))
        |-> dbg == $past(debug_mode, 2))
        else $error("debug level not two flops late");

    level_wait_a: assert property (
        (lvl_os && run_eff && !s_ff.started && !start_q)
        |=> !s_ff.started)
        else $error("level one-shot started on wrong level");

    level_load_a: assert property (
        (lvl_rst && run_eff && !reserved)
        |=> s_ff.holdoff == `HLT_HOLD_CYCLES)
        else $error("level reset did not load holdoff");

    reserved_hold_a: assert property (
        reserved |=> $stable(s_ff.count))
        else $error("reserved mode moved the count");

    read_idle_a: assert property (
        !$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");

    debug_ignore_a: assert property (
        dbg |-> !rise && !fall && !edge_rst)
        else $error("trigger seen during debug");

    level_reset_a: assert property (
        (lvl_rst && run_eff && !reserved) |=> s_ff.count == 8'h00)
        else $error("level reset did not hold count");

endmodule : hlt_timer

// >>> tb/hlt_ers_src.sv
// Purpose: Far-side source of the external reset signal
// Assumes: One timer clock; tb asks for a level, model applies it
// Notes: Never toggles faster than the timer can resolve
`timescale 1ns/10ps

module hlt_ers_src (
    input wire logic clock,
    input wire logic rst,
    input wire logic want,
    output logic ers
);
    logic [3:0] age_ff;
    logic ers_ff;

    // Changes held back until seven clocks since the last one
    always_ff @(posedge clock) begin
        if (rst) begin
            ers_ff <= 1'b0;
            age_ff <= 4'h0;
        end else if (want != ers_ff && age_ff >= 4'h6) begin
            ers_ff <= want;
            age_ff <= 4'h0;
        end else if (age_ff != 4'hF) begin
            age_ff <= age_ff + 4'h1;
        end
    end

    assign ers = ers_ff;
endmodule : hlt_ers_src

// >>> tb/tb_hardware_limit_period_timer.sv
// Purpose: Self-checking bench for the hardware limit period timer
// Assumes: Outputs sampled at the rising edge, before its updates land
// Notes: Fast run handling used in every test but t_slow to keep waits short
`timescale 1ns/10ps

module tb_hardware_limit_period_timer;
    import hlt_pkg::*;
    logic clock;
    logic rst;
    hlt_bus_req_t bus;
    logic [7:0] rdata;
    logic debug_mode;
    logic want;
    logic ers;
    hlt_time_base_t time_base;
    int n_errors;
    int comparisons;
    logic [7:0] c;

    hlt_ers_src src (.clock(clock), .rst(rst), .want(want), .ers(ers));
    hlt_timer dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
        .external_reset_signal(ers), .debug_mode(debug_mode),
        .time_base(time_base));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task summarize;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask : wr

    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '0;
        @(posedge clock);
        chk(rdata === e, "read data");
    endtask : rd

    // Bounded wait; a hang ends the run through the report
    task wait_cnt(input logic [7:0] v);
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge clock);
            if (time_base.count === v) return;
        end
        n_errors++;
        $display("MISMATCH %0t count never reached", $time);
        summarize();
    endtask : wait_cnt

    task t_regs;
        rd(3'h2, 8'hFF);
        rd(3'h7, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task t_soft;
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h03);
        wr(3'h0, 8'h03);
        wait_cnt(8'h03);
        @(posedge clock);
        chk(time_base.count === 8'h00 && time_base.match === 1'b1, "wrap");
        chk(time_base.counting === 1'b1, "counting flag");
        @(posedge clock);
        chk(time_base.count === 8'h01, "after wrap");
        wr(3'h0, 8'h02);
        repeat (3) @(posedge clock);
        c = time_base.count;
        repeat (4) @(posedge clock);
        chk(time_base.count === c, "hold when stopped");
        chk(time_base.counting === 1'b0, "idle flag");
        $display("test soft gate done");
    endtask : t_soft

    task t_gate;
        wr(3'h2, 8'hFF);
        wr(3'h1, 8'h01);
        wr(3'h0, 8'h03);
        repeat (6) @(posedge clock);
        c = time_base.count;
        repeat (5) @(posedge clock);
        chk(time_base.count === c, "gated low");
        want <= 1'b1;
        repeat (12) @(posedge clock);
        chk(time_base.count !== c, "gate open");
        want <= 1'b0;
        repeat (12) @(posedge clock);
        $display("test hw gate done");
    endtask : t_gate

    task t_limit;
        wr(3'h1, 8'h04);
        repeat (10) @(posedge clock);
        want <= 1'b1;
        wait_cnt(8'h00);
        repeat (2) begin
            @(posedge clock);
            chk(time_base.count === 8'h00, "holdoff");
        end
        @(posedge clock);
        chk(time_base.count === 8'h01, "resume");
        $display("test edge limit done");
    endtask : t_limit

    task t_debug;
        debug_mode <= 1'b1;
        want <= 1'b0;
        repeat (12) @(posedge clock);
        want <= 1'b1;
        repeat (12) @(posedge clock);
        chk(time_base.count > 8'h10, "edge in debug");
        debug_mode <= 1'b0;
        $display("test debug done");
    endtask : t_debug

    task t_one;
        wr(3'h0, 8'h02);
        wr(3'h2, 8'h02);
        wr(3'h1, 8'h08);
        wr(3'h0, 8'h03);
        wait_cnt(8'h02);
        @(posedge clock);
        chk(time_base.count === 8'h00, "one-shot end");
        rd(3'h0, 8'h02);
        chk(time_base.count === 8'h00, "stopped at zero");
        $display("test one-shot done");
    endtask : t_one

    task t_slow;
        wr(3'h1, 8'h00);
        wr(3'h2, 8'hFF);
        wr(3'h0, 8'h00);
        wr(3'h0, 8'h01);
        repeat (3) begin
            @(posedge clock);
            chk(time_base.count === 8'h00, "slow run delay");
        end
        @(posedge clock);
        chk(time_base.count === 8'h01, "slow run start");
        wr(3'h0, 8'h00);
        $display("test slow run done");
    endtask : t_slow

    task t_mono;
        want <= 1'b0;
        wr(3'h0, 8'h02);
        wr(3'h2, 8'h08);
        wr(3'h1, 8'h11);
        wr(3'h0, 8'h03);
        c = time_base.count;
        repeat (6) @(posedge clock);
        chk(time_base.count === c, "no start without edge");
        want <= 1'b1;
        wait_cnt(8'h08);
        @(posedge clock);
        chk(time_base.count === 8'h00 && time_base.match === 1'b1, "mono end");
        repeat (4) @(posedge clock);
        chk(time_base.count === 8'h00, "mono stopped");
        rd(3'h0, 8'h03);
        want <= 1'b0;
        repeat (8) @(posedge clock);
        want <= 1'b1;
        wait_cnt(8'h02);
        $display("test monostable done");
    endtask : t_mono

    initial begin
        rst = 1'b1;
        bus = '0;
        debug_mode = 1'b0;
        want = 1'b0;
        n_errors = 0;
        comparisons = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_soft();
        t_gate();
        t_limit();
        t_debug();
        t_one();
        t_slow();
        t_mono();
        summarize();
    end
endmodule : tb_hardware_limit_period_timer
